// ---- dual_counter_timer.v ----
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.vh"
module dual_counter_timer (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire t0_event_pin,
    input wire t1_event_pin,
    input wire t0_gate_input,
    input wire t1_gate_input,
    input wire ext_clock_pin,
    input wire t0_irq_enable,
    input wire t1_irq_enable,
    input wire t0_irq_ack,
    input wire t1_irq_ack,
    output wire t0_irq,
    output wire t1_irq,
    output wire irq
);
    reg [7:0] timer_control_reg;
    reg [7:0] timer_mode_reg;
    reg [7:0] timer_clock_reg;
    reg [7:0] ext_input_config_reg;
    reg [1:0] irq_status;
    reg [1:0] irq_mask;
    reg [5:0] pre_cnt;
    reg prescale_tick;
    reg ext_meta;
    reg ext_sync;
    reg ext_prev;
    wire [7:0] t0_low;
    wire [7:0] t0_high;
    wire [7:0] t1_low;
    wire [7:0] t1_high;
    wire t0_ovf;
    wire t1_ovf;
    wire [1:0] prescale_select = timer_clock_reg[`CLK_PRESCALE_LSB+1:`CLK_PRESCALE_LSB];
    wire wr = psel & penable & pwrite;

    // decode one register offset
    function hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    function mapped;
        input [11:0] addr;
        begin
            mapped = (addr[1:0] == 2'b00) && (addr <= `OFS_IRQ_MASK);
        end
    endfunction

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped(paddr);

    // external clock pin synchronised for the div8 source
    always @(posedge clk) begin
        if (sys_rst) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= ext_clock_pin;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // prescaler producing one-cycle ticks
    always @(posedge clk) begin
        if (sys_rst) begin
            pre_cnt <= 6'd0;
            prescale_tick <= 1'b0;
        end else begin
            prescale_tick <= 1'b0;
            case (prescale_select)
                `PRE_DIV12: begin
                    pre_cnt <= (pre_cnt >= `DIV12_LAST) ? 6'd0 : pre_cnt + 6'd1;
                    prescale_tick <= (pre_cnt >= `DIV12_LAST);
                end
                `PRE_DIV4: begin
                    pre_cnt <= (pre_cnt >= `DIV4_LAST) ? 6'd0 : pre_cnt + 6'd1;
                    prescale_tick <= (pre_cnt >= `DIV4_LAST);
                end
                `PRE_DIV48: begin
                    pre_cnt <= (pre_cnt >= `DIV48_LAST) ? 6'd0 : pre_cnt + 6'd1;
                    prescale_tick <= (pre_cnt >= `DIV48_LAST);
                end
                default: begin
                    if (ext_sync & ~ext_prev) begin
                        pre_cnt <= (pre_cnt >= `EXT8_LAST) ? 6'd0 : pre_cnt + 6'd1;
                        prescale_tick <= (pre_cnt >= `EXT8_LAST);
                    end
                end
            endcase
        end
    end

    timer_channel u_t0 (
        .clk(clk),
        .sys_rst(sys_rst),
        .mode_nibble(timer_mode_reg[`MODE_T0_LSB+3:`MODE_T0_LSB]),
        .run_bit(timer_control_reg[`CTL_T0_RUN]),
        .system_clock_select(timer_clock_reg[`CLK_T0_SYS]),
        .prescale_tick(prescale_tick),
        .event_pin(t0_event_pin),
        .gate_input(t0_gate_input),
        .gate_polarity(ext_input_config_reg[`EXT_T0_POL]),
        .wr_low(wr & hit(paddr, `OFS_T0_LOW)),
        .wr_high(wr & hit(paddr, `OFS_T0_HIGH)),
        .wdata(pwdata[7:0]),
        .count_low_byte(t0_low),
        .count_high_byte(t0_high),
        .overflow_pulse(t0_ovf)
    );

    // second timer, own bytes, bits, gate and polarity
    timer_channel u_t1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .mode_nibble(timer_mode_reg[`MODE_T1_LSB+3:`MODE_T1_LSB]),
        .run_bit(timer_control_reg[`CTL_T1_RUN]),
        .system_clock_select(timer_clock_reg[`CLK_T1_SYS]),
        .prescale_tick(prescale_tick),
        .event_pin(t1_event_pin),
        .gate_input(t1_gate_input),
        .gate_polarity(ext_input_config_reg[`EXT_T1_POL]),
        .wr_low(wr & hit(paddr, `OFS_T1_LOW)),
        .wr_high(wr & hit(paddr, `OFS_T1_HIGH)),
        .wdata(pwdata[7:0]),
        .count_low_byte(t1_low),
        .count_high_byte(t1_high),
        .overflow_pulse(t1_ovf)
    );

    // control, mode, clock and config registers with overflow flags
    always @(posedge clk) begin
        if (sys_rst) begin
            timer_control_reg <= `RESET_BYTE;
            timer_mode_reg <= `RESET_BYTE;
            timer_clock_reg <= `RESET_BYTE;
            ext_input_config_reg <= `RESET_BYTE;
            irq_mask <= 2'b00;
        end else begin
            if (wr & hit(paddr, `OFS_CONTROL)) begin
                timer_control_reg <= pwdata[7:0];
            end
            if (wr & hit(paddr, `OFS_MODE)) begin
                timer_mode_reg <= pwdata[7:0];
            end
            if (wr & hit(paddr, `OFS_CLOCK)) begin
                timer_clock_reg <= pwdata[7:0];
            end
            if (wr & hit(paddr, `OFS_EXT_CFG)) begin
                ext_input_config_reg <= pwdata[7:0];
            end
            if (wr & hit(paddr, `OFS_IRQ_MASK)) begin
                irq_mask <= pwdata[1:0];
            end
            // acknowledge clears, overflow set wins
            if (t0_irq_ack) begin
                timer_control_reg[`CTL_T0_OVF] <= 1'b0;
            end
            if (t1_irq_ack) begin
                timer_control_reg[`CTL_T1_OVF] <= 1'b0;
            end
            if (t0_ovf) begin
                timer_control_reg[`CTL_T0_OVF] <= 1'b1;
            end
            if (t1_ovf) begin
                timer_control_reg[`CTL_T1_OVF] <= 1'b1;
            end
        end
    end

    // sticky status, write one to clear, set wins
    always @(posedge clk) begin
        if (sys_rst) begin
            irq_status <= 2'b00;
        end else begin
            irq_status <= (irq_status & ~((wr & hit(paddr, `OFS_IRQ_STATUS)) ?
                pwdata[1:0] : 2'b00)) | {t1_ovf, t0_ovf};
        end
    end

    assign t0_irq = timer_control_reg[`CTL_T0_OVF] & t0_irq_enable;
    assign t1_irq = timer_control_reg[`CTL_T1_OVF] & t1_irq_enable;
    assign irq = |(irq_status & irq_mask);

    // read data captured in the setup cycle, held through the access phase
    always @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable) begin
            prdata <= 32'h0000_0000;
            case (paddr)
                `OFS_CONTROL: prdata[7:0] <= timer_control_reg;
                `OFS_MODE: prdata[7:0] <= timer_mode_reg;
                `OFS_CLOCK: prdata[7:0] <= timer_clock_reg;
                `OFS_T0_LOW: prdata[7:0] <= t0_low;
                `OFS_T0_HIGH: prdata[7:0] <= t0_high;
                `OFS_T1_LOW: prdata[7:0] <= t1_low;
                `OFS_T1_HIGH: prdata[7:0] <= t1_high;
                `OFS_EXT_CFG: prdata[7:0] <= ext_input_config_reg;
                `OFS_IRQ_STATUS: prdata[1:0] <= irq_status;
                `OFS_IRQ_MASK: prdata[1:0] <= irq_mask;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- timer_map.vh ----
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH
// apb byte offsets
`define OFS_CONTROL 12'h000
`define OFS_MODE 12'h004
`define OFS_CLOCK 12'h008
`define OFS_T0_LOW 12'h00c
`define OFS_T0_HIGH 12'h010
`define OFS_T1_LOW 12'h014
`define OFS_T1_HIGH 12'h018
`define OFS_EXT_CFG 12'h01c
`define OFS_IRQ_STATUS 12'h020
`define OFS_IRQ_MASK 12'h024
// control register fields
`define CTL_T0_RUN 4
`define CTL_T0_OVF 5
`define CTL_T1_RUN 6
`define CTL_T1_OVF 7
// mode register fields, per timer nibble
`define MODE_T0_LSB 0
`define MODE_T1_LSB 4
`define MODE_SEL_HI 1
`define MODE_SRC 2
`define MODE_GATE 3
// mode codes
`define MODE_13BIT 2'b00
`define MODE_16BIT 2'b01
`define MODE_RELOAD 2'b10
`define MODE_SPLIT 2'b11
// clock register fields
`define CLK_PRESCALE_LSB 0
`define CLK_T0_SYS 3
`define CLK_T1_SYS 4
// ext config fields
`define EXT_T0_POL 0
`define EXT_T1_POL 1
// prescale codes and divisors
`define PRE_DIV12 2'b00
`define PRE_DIV4 2'b01
`define PRE_DIV48 2'b10
`define PRE_EXT8 2'b11
`define DIV12_LAST 6'd11
`define DIV4_LAST 6'd3
`define DIV48_LAST 6'd47
`define EXT8_LAST 6'd7
`define RESET_BYTE 8'h00
`endif

// ---- timer_channel.v ----
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.vh"
module timer_channel (
    input wire clk,
    input wire sys_rst,
    input wire [3:0] mode_nibble,
    input wire run_bit,
    input wire system_clock_select,
    input wire prescale_tick,
    input wire event_pin,
    input wire gate_input,
    input wire gate_polarity,
    input wire wr_low,
    input wire wr_high,
    input wire [7:0] wdata,
    output reg [7:0] count_low_byte,
    output reg [7:0] count_high_byte,
    output reg overflow_pulse
);
    reg event_meta;
    reg event_sync;
    reg event_prev;
    wire [1:0] mode_sel = mode_nibble[`MODE_SEL_HI:0];
    wire count_source_select = mode_nibble[`MODE_SRC];
    wire gate_bit = mode_nibble[`MODE_GATE];
    wire falling = event_prev & ~event_sync;
    wire gate_ok = ~gate_bit | (gate_input == gate_polarity);
    wire enable = run_bit & gate_ok;
    wire tick = count_source_select ? falling : (system_clock_select | prescale_tick);
    wire step = enable & tick & (mode_sel != `MODE_SPLIT);

    // two-flop synchroniser then edge compare
    always @(posedge clk) begin
        if (sys_rst) begin
            event_meta <= 1'b1;
            event_sync <= 1'b1;
            event_prev <= 1'b1;
        end else begin
            event_meta <= event_pin;
            event_sync <= event_meta;
            event_prev <= event_sync;
        end
    end

    // count bytes; software writes win, run does not preload
    always @(posedge clk) begin
        if (sys_rst) begin
            count_low_byte <= `RESET_BYTE;
            count_high_byte <= `RESET_BYTE;
            overflow_pulse <= 1'b0;
        end else begin
            overflow_pulse <= 1'b0;
            if (step) begin
                case (mode_sel)
                    `MODE_13BIT: begin
                        count_low_byte[4:0] <= count_low_byte[4:0] + 5'd1;
                        if (&count_low_byte[4:0]) begin
                            count_high_byte <= count_high_byte + 8'd1;
                            overflow_pulse <= &count_high_byte;
                        end
                    end
                    `MODE_16BIT: begin
                        count_low_byte <= count_low_byte + 8'd1;
                        if (&count_low_byte) begin
                            count_high_byte <= count_high_byte + 8'd1;
                            overflow_pulse <= &count_high_byte;
                        end
                    end
                    `MODE_RELOAD: begin
                        if (&count_low_byte) begin
                            count_low_byte <= count_high_byte;
                            overflow_pulse <= 1'b1;
                        end else begin
                            count_low_byte <= count_low_byte + 8'd1;
                        end
                    end
                    default: begin
                        overflow_pulse <= 1'b0;
                    end
                endcase
            end
            if (wr_low) begin
                count_low_byte <= wdata;
            end
            if (wr_high) begin
                count_high_byte <= wdata;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tmr_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmr_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic t0_irq_enable,
    input wire logic t1_irq_enable,
    input wire logic t0_irq_ack,
    input wire logic t0_irq,
    input wire logic t1_irq,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // access phase of a transfer
    wire acc = psel && penable;
    a_ready_now: assert property (acc |-> pready) else $error("pready low");
    a_err_unmapped: assert property (acc && paddr > 12'h024 |-> pslverr)
        else $error("no slverr");
    a_err_mapped: assert property (acc && paddr <= 12'h024 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("bad slverr");
    a_rd_err_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_rd_byte_only: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_t0_irq_gated: assert property (!t0_irq_enable |-> !t0_irq) else $error("t0 irq");
    a_t1_irq_gated: assert property (!t1_irq_enable |-> !t1_irq) else $error("t1 irq");
    a_irq_fall_cause: assert property ($fell(irq) |-> $past(acc && pwrite))
        else $error("irq fell without write");
    a_t0_fall_cause: assert property ($fell(t0_irq) |->
        !t0_irq_enable || $past(t0_irq_ack) || $past(acc && pwrite))
        else $error("t0 irq fell without cause");
endmodule
`default_nettype wire

// ---- event_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module event_src (
    input wire logic clk,
    output logic t0_event_pin,
    output logic t1_event_pin,
    output logic t0_gate_input,
    output logic t1_gate_input,
    output logic ext_clock_pin
);
    // idle high event pins, gate inputs low, external clock still
    initial begin
        t0_event_pin = 1'b1;
        t1_event_pin = 1'b1;
        t0_gate_input = 1'b0;
        t1_gate_input = 1'b0;
        ext_clock_pin = 1'b0;
    end
    // n falling edges, two clocks per level: quarter of the clock rate
    task automatic pulses(input int ch, input int n);
        repeat (n) begin
            @(posedge clk);
            if (ch == 0) t0_event_pin <= 1'b0; else t1_event_pin <= 1'b0;
            repeat (2) @(posedge clk);
            if (ch == 0) t0_event_pin <= 1'b1; else t1_event_pin <= 1'b1;
            @(posedge clk);
        end
    endtask
    // n rising edges on the external clock, four clocks apart
    task automatic extclk(input int n);
        repeat (n) begin
            @(posedge clk);
            ext_clock_pin <= 1'b1;
            repeat (2) @(posedge clk);
            ext_clock_pin <= 1'b0;
            @(posedge clk);
        end
    endtask
    // second gate level
    task automatic gate1(input logic v);
        @(posedge clk);
        t1_gate_input <= v;
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.vh"
`define CHK(nm, e, v) begin checks_done++; if ((v) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, e, v); end end
module tb_top;
    logic clk, sys_rst, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic t0_irq_enable, t1_irq_enable, t0_irq_ack, t1_irq_ack;
    wire [31:0] prdata;
    wire pready, pslverr, t0_irq, t1_irq, irq, ext_clock_pin;
    wire t0_event_pin, t1_event_pin, t0_gate_input, t1_gate_input;
    int n_mismatch = 0, checks_done = 0, i;
    logic [31:0] cks[5] = '{32'h08, 32'h00, 32'h01, 32'h02, 32'h03};
    int lo[5] = '{33, 199, 215, 193, 193};
    logic [31:0] hi[5] = '{32'h00, 32'hff, 32'hff, 32'hff, 32'hff};
    dual_counter_timer dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .t0_event_pin, .t1_event_pin, .t0_gate_input,
        .t1_gate_input, .ext_clock_pin, .t0_irq_enable, .t1_irq_enable, .t0_irq_ack,
        .t1_irq_ack, .t0_irq, .t1_irq, .irq);
    event_src src (.clk, .t0_event_pin, .t1_event_pin, .t0_gate_input, .t1_gate_input,
        .ext_clock_pin);
    task automatic end_sim();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one apb transfer from just after an edge; answer taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            n_mismatch++;
            end_sim();
        end
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, rd)
    endtask
    task automatic ev(input int ch, input int n);
        src.pulses(ch, n);
        repeat (6) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {sys_rst, t0_irq_enable} = 2'b11;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {t1_irq_enable, t0_irq_ack, t1_irq_ack} = 3'b000;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rchk(`OFS_T0_HIGH, 32'h0);
        rchk(12'h040, 32'h0);
        `CHK("slverr", 1'b1, err)
        // 13-bit mode counting event pin edges
        wr(`OFS_MODE, 32'h04);
        wr(`OFS_T0_LOW, 32'h1e);
        wr(`OFS_T0_HIGH, 32'hff);
        wr(`OFS_IRQ_MASK, 32'h3);
        wr(`OFS_CONTROL, 32'h10);
        rchk(`OFS_T0_LOW, 32'h1e);
        ev(0, 1);
        rchk(`OFS_T0_LOW, 32'h1f);
        `CHK("irq", 1'b0, irq)
        ev(0, 1);
        rchk(`OFS_T0_HIGH, 32'h00);
        rchk(`OFS_CONTROL, 32'h30);
        `CHK("t0_irq", 1'b1, t0_irq)
        // second timer: gated reload mode
        wr(`OFS_MODE, 32'he4);
        wr(`OFS_EXT_CFG, 32'h2);
        wr(`OFS_T1_HIGH, 32'hf0);
        wr(`OFS_T1_LOW, 32'hfe);
        wr(`OFS_CONTROL, 32'h70);
        ev(1, 2);
        rchk(`OFS_T1_LOW, 32'hfe);
        src.gate1(1'b1);
        ev(1, 2);
        rchk(`OFS_T1_LOW, 32'hf0);
        ev(1, 1);
        rchk(`OFS_T1_LOW, 32'hf1);
        rchk(`OFS_T1_HIGH, 32'hf0);
        rchk(`OFS_IRQ_STATUS, 32'h3);
        `CHK("irq", 1'b1, irq)
        `CHK("t1_irq", 1'b0, t1_irq)
        @(posedge clk) t1_irq_enable <= 1'b1;
        @(posedge clk) `CHK("t1_irq", 1'b1, t1_irq)
        // masking, clearing, acknowledging
        wr(`OFS_IRQ_MASK, 32'h0);
        `CHK("irq", 1'b0, irq)
        wr(`OFS_IRQ_STATUS, 32'h1);
        rchk(`OFS_IRQ_STATUS, 32'h2);
        @(posedge clk) t0_irq_ack <= 1'b1;
        @(posedge clk) t0_irq_ack <= 1'b0;
        rchk(`OFS_CONTROL, 32'hd0);
        `CHK("t0_irq", 1'b0, t0_irq)
        @(posedge clk) t1_irq_ack <= 1'b1;
        @(posedge clk) t1_irq_ack <= 1'b0;
        rchk(`OFS_CONTROL, 32'h50);
        `CHK("t1_irq", 1'b0, t1_irq)
        wr(`OFS_CONTROL, 32'h0);
        rchk(`OFS_CONTROL, 32'h0);
        @(posedge clk) t0_irq_enable <= 1'b0;
        // system clock, prescaler and external clock choices in 16-bit mode
        for (i = 0; i < 5; i++) begin
            wr(`OFS_MODE, 32'h01);
            wr(`OFS_T0_LOW, 32'hc0);
            wr(`OFS_T0_HIGH, 32'hff);
            wr(`OFS_CLOCK, cks[i]);
            wr(`OFS_CONTROL, 32'h10);
            if (i == 4) src.extclk(24);
            else repeat (96) @(posedge clk);
            wr(`OFS_CONTROL, 32'h0);
            rchk(`OFS_T0_HIGH, hi[i]);
            apb(1'b0, `OFS_T0_LOW, 32'h0);
            `CHK("count", 1'b1, (rd >= lo[i] && rd <= lo[i] + 2))
        end
        // the left-out mode code holds the count
        wr(`OFS_MODE, 32'h03);
        wr(`OFS_CLOCK, 32'h08);
        wr(`OFS_T0_LOW, 32'h5a);
        wr(`OFS_CONTROL, 32'h10);
        repeat (8) @(posedge clk);
        rchk(`OFS_T0_LOW, 32'h5a);
        end_sim();
    end
endmodule
bind dual_counter_timer tmr_chk chk (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .t0_irq_enable, .t1_irq_enable, .t0_irq_ack, .t0_irq,
    .t1_irq, .irq);
`default_nettype wire
